// File: logic/adcsl_defines.vh
// constants and rule summary for the converter two-wire slave port
// Operation
// - data line stays stable while clock high; changes then are control conditions
// - data falling while clock high is a start and opens a transfer
// - data rising while clock high is a stop and ends the transfer
// - eight data bits per byte, then a ninth acknowledge bit from the receiver
// - works at standard, fast and high-speed clock rates
// - acknowledger holds data low through the whole acknowledge clock high
// - after master not-acknowledge on a read, release data high for the stop
// - on a write, acknowledge the address and every data byte received
// - stop or repeated start ends a transfer; repeated start keeps the bus
// - first byte is address, msb first: type prefix, two select bits, direction
// - select bits are the select pin levels sampled at power-up
// - direction bit 1 means read, 0 means write
// - acknowledge only a full match; then receiver for write, transmitter for read
// - as transmitter, shift data out on master clock, still seeing start and stop
// - command byte: config bit, three channel bits, two power bits, two ignored
// - channel decode per differential pairs or single-ended against common input
// - power field: 00 down between, 01 ref off, 10 ref on conv off, 11 both on
// - write-addressed: start conversion at command bit 4, acknowledge the command
// - acknowledge a valid command byte at its end
// - result goes out as zero nibble plus bits 11..8, then bits 7..0
// - high-speed read: hold clock low after read address until conversion done
// - stop leaves high-speed operation; repeated start keeps it
`ifndef ADCSL_DEFINES_VH
`define ADCSL_DEFINES_VH
// device-type prefix; value is arbitrary
`define ADCSL_TYPE_PREFIX    5'h0b
// prefix of the high-speed master code byte
`define ADCSL_MCODE_PREFIX   5'h01
`define ADCSL_BYTE_BITS      4'h8
`define ADCSL_CHAN_BITS_DONE 4'h3
`define ADCSL_DIR_READ       1'b1
`define ADCSL_STRAP_WAIT     2'h3
`define ADCSL_RESULT_W       12
`define ADCSL_POWER_RESET    2'h0
`define ADCSL_CHAN_RESET     3'h0
`endif

// File: logic/adcsl_sync.v
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module adcsl_sync #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         rst,
   input  wire [W-1:0] din,
   output reg  [W-1:0] dout
);
   reg [W-1:0] meta_q;

   // first stage feeds the second stage only
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= {W{1'b1}};
         dout   <= {W{1'b1}};
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule

// File: logic/adcsl_buf.v
// two-entry result buffer with valid and ready on both sides
`timescale 1ns/1ps
module adcsl_buf #(
   parameter W = 12
) (
   input  wire         clk,
   input  wire         rst,
   input  wire         in_valid,
   output reg          in_ready,
   input  wire [W-1:0] in_data,
   output reg          out_valid,
   input  wire         out_ready,
   output wire [W-1:0] out_data
);
   reg [W-1:0] mem0_q;
   reg [W-1:0] mem1_q;
   reg         wr_q;
   reg         rd_q;
   reg [1:0]   cnt_q;
   reg [1:0]   cnt_d;
   wire        push;
   wire        pop;

   assign push     = in_valid & in_ready;
   assign pop      = out_valid & out_ready;
   assign out_data = rd_q ? mem1_q : mem0_q;

   always @* begin
      cnt_d = cnt_q;
      if (push & ~pop)
         cnt_d = cnt_q + 2'h1;
      else if (pop & ~push)
         cnt_d = cnt_q - 2'h1;
   end

   // ready drops only when both entries hold unread words
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         mem0_q    <= {W{1'b0}};
         mem1_q    <= {W{1'b0}};
         wr_q      <= 1'b0;
         rd_q      <= 1'b0;
         cnt_q     <= 2'h0;
         in_ready  <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         if (push) begin
            if (wr_q)
               mem1_q <= in_data;
            else
               mem0_q <= in_data;
            wr_q <= ~wr_q;
         end
         if (pop)
            rd_q <= ~rd_q;
         cnt_q     <= cnt_d;
         in_ready  <= (cnt_d != 2'h2);
         out_valid <= (cnt_d != 2'h0);
      end
   end
endmodule

// File: logic/adcsl_slave.v
// two-wire slave command and result port of the sampling converter
`timescale 1ns/1ps
`include "adcsl_defines.vh"
module adcsl_slave (
   input  wire        clk,
   input  wire        rst,
   input  wire        scl_in,
   output reg         scl_out,
   output reg         scl_oe,
   input  wire        sda_in,
   output reg         sda_out,
   output reg         sda_oe,
   input  wire        device_select_high_pin,
   input  wire        device_select_low_pin,
   input  wire        conv_result_valid,
   output wire        conv_result_ready,
   input  wire [11:0] conv_result,
   output reg         conv_start,
   output reg         single_ended_select,
   output reg  [2:0]  channel_select_bits,
   output reg         power_mode_high_bit,
   output reg         power_mode_low_bit,
   output reg  [2:0]  pos_input_sel,
   output reg  [2:0]  neg_input_sel,
   output reg         neg_is_common,
   output reg         high_speed_operation,
   output reg         addressed
);
   localparam [3:0] S_IDLE    = 4'h0;
   localparam [3:0] S_ADDR    = 4'h1;
   localparam [3:0] S_AACK    = 4'h2;
   localparam [3:0] S_CMD     = 4'h3;
   localparam [3:0] S_CACK    = 4'h4;
   localparam [3:0] S_TX      = 4'h5;
   localparam [3:0] S_TACK    = 4'h6;
   localparam [3:0] S_STRETCH = 4'h7;
   localparam [3:0] S_IGNORE  = 4'h8;
   localparam [1:0] PWR_RST   = `ADCSL_POWER_RESET;

   wire [3:0]  pins_s;
   wire        scl_s;
   wire        sda_s;
   reg         scl_p_q;
   reg         sda_p_q;
   wire        scl_rise;
   wire        scl_fall;
   wire        start_det;
   wire        stop_det;

   reg  [1:0]  strap_cnt_q;
   reg  [1:0]  select_q;

   reg  [3:0]  state_q;
   reg  [3:0]  cnt_q;
   reg  [7:0]  shift_q;
   reg  [7:0]  tx_q;
   reg         byte_sel_q;
   reg         master_ack_q;
   reg  [11:0] result_q;
   reg         pop_q;
   wire        buf_valid;
   wire [11:0] buf_data;
   wire [7:0]  next_byte;
   wire [3:0]  cnt_inc;
   wire        addr_match;
   wire        mcode_seen;

   adcsl_sync #(
      .W (4)
   ) u_sync (
      .clk  (clk),
      .rst  (rst),
      .din  ({scl_in, sda_in, device_select_high_pin, device_select_low_pin}),
      .dout (pins_s)
   );

   // a stall on the read side backs up into the converter, so no word is lost
   adcsl_buf #(
      .W (`ADCSL_RESULT_W)
   ) u_buf (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (conv_result_valid),
      .in_ready  (conv_result_ready),
      .in_data   (conv_result),
      .out_valid (buf_valid),
      .out_ready (pop_q),
      .out_data  (buf_data)
   );

   assign scl_s = pins_s[3];
   assign sda_s = pins_s[2];

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   // the clock is sampled, so bus rates well below clk/4 only; faster bus
   // clocks need a faster clk
   assign scl_rise  = scl_s & ~scl_p_q;
   assign scl_fall  = ~scl_s & scl_p_q;
   assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;

   // select pins caught on the first three cycles; the last, taken after the synchroniser has settled, is kept
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         strap_cnt_q <= 2'h0;
         select_q    <= 2'h0;
      end else if (strap_cnt_q != `ADCSL_STRAP_WAIT) begin
         strap_cnt_q <= strap_cnt_q + 2'h1;
         select_q    <= pins_s[1:0];
      end
   end

   assign cnt_inc    = cnt_q + 4'h1;
   // address byte arrives msb first: prefix, select bits, direction
   assign addr_match = (shift_q[7:3] == `ADCSL_TYPE_PREFIX) &&
                       (shift_q[2:1] == select_q);
   assign mcode_seen = (shift_q[7:3] == `ADCSL_MCODE_PREFIX);

   // first byte carries four zeros above result bits 11..8
   assign next_byte  = byte_sel_q ? result_q[7:0] :
                       buf_valid ? {4'h0, buf_data[11:8]} :
                       {4'h0, result_q[11:8]};

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q              <= S_IDLE;
         cnt_q                <= 4'h0;
         shift_q              <= 8'h00;
         tx_q                 <= 8'h00;
         byte_sel_q           <= 1'b0;
         master_ack_q         <= 1'b0;
         result_q             <= 12'h000;
         pop_q                <= 1'b0;
         sda_oe               <= 1'b0;
         sda_out              <= 1'b0;
         scl_oe               <= 1'b0;
         scl_out              <= 1'b0;
         conv_start           <= 1'b0;
         single_ended_select  <= 1'b0;
         channel_select_bits  <= `ADCSL_CHAN_RESET;
         power_mode_high_bit  <= PWR_RST[1];
         power_mode_low_bit   <= PWR_RST[0];
         pos_input_sel        <= 3'h0;
         neg_input_sel        <= 3'h1;
         neg_is_common        <= 1'b0;
         high_speed_operation <= 1'b0;
         addressed            <= 1'b0;
      end else begin
         conv_start <= 1'b0;
         pop_q      <= 1'b0;
         // the bus master owns every clock pulse and condition
         if (start_det) begin
            // a repeated start reopens addressing and keeps high speed
            state_q   <= S_ADDR;
            cnt_q     <= 4'h0;
            sda_oe    <= 1'b0;
            scl_oe    <= 1'b0;
            addressed <= 1'b0;
         end else if (stop_det) begin
            state_q              <= S_IDLE;
            sda_oe               <= 1'b0;
            scl_oe               <= 1'b0;
            addressed            <= 1'b0;
            high_speed_operation <= 1'b0;
         end else begin
            case (state_q)
               S_IDLE: begin
                  sda_oe <= 1'b0;
               end
               S_ADDR: begin
                  if (scl_rise) begin
                     shift_q <= {shift_q[6:0], sda_s};
                     cnt_q   <= cnt_inc;
                  end else if (scl_fall && cnt_q == `ADCSL_BYTE_BITS) begin
                     cnt_q <= 4'h0;
                     if (addr_match) begin
                        sda_oe     <= 1'b1;
                        addressed  <= 1'b1;
                        byte_sel_q <= 1'b0;
                        state_q    <= S_AACK;
                     end else begin
                        // master code is never acknowledged by a slave
                        if (mcode_seen)
                           high_speed_operation <= 1'b1;
                        state_q <= S_IGNORE;
                     end
                  end
               end
               S_AACK: begin
                  // data held low until the acknowledge clock falls
                  if (scl_fall) begin
                     if (shift_q[0] == `ADCSL_DIR_READ) begin
                        if (high_speed_operation && !buf_valid) begin
                           sda_oe  <= 1'b0;
                           scl_oe  <= 1'b1;
                           state_q <= S_STRETCH;
                        end else begin
                           tx_q       <= next_byte;
                           sda_oe     <= ~next_byte[7];
                           byte_sel_q <= ~byte_sel_q;
                           if (buf_valid) begin
                              result_q <= buf_data;
                              pop_q    <= 1'b1;
                           end
                           state_q <= S_TX;
                        end
                     end else begin
                        sda_oe  <= 1'b0;
                        state_q <= S_CMD;
                     end
                  end
               end
               S_STRETCH: begin
                  // clock held low until the conversion result is
                  // data is set up a cycle before the clock is let go
                  if (sda_oe) begin
                     scl_oe  <= 1'b0;
                     state_q <= S_TX;
                  end else if (buf_valid) begin
                     tx_q       <= {4'h0, buf_data[11:8]};
                     sda_oe     <= 1'b1; // byte 0 opens with a zero bit
                     result_q   <= buf_data;
                     pop_q      <= 1'b1;
                     byte_sel_q <= 1'b1;
                  end
               end
               S_CMD: begin
                  if (scl_rise) begin
                     shift_q <= {shift_q[6:0], sda_s};
                     cnt_q   <= cnt_inc;
                     // bit 4 is the last channel bit: convert at once
                     if (cnt_q == `ADCSL_CHAN_BITS_DONE) begin
                        conv_start          <= 1'b1;
                        single_ended_select <= shift_q[2];
                        channel_select_bits <= {shift_q[1:0], sda_s};
                        // even input of pair from low bits, top bit picks odd
                        pos_input_sel       <= {shift_q[0], sda_s, shift_q[1]};
                        neg_input_sel       <= {shift_q[0], sda_s, ~shift_q[1]};
                        neg_is_common       <= shift_q[2];
                     end
                  end else if (scl_fall && cnt_q == `ADCSL_BYTE_BITS) begin
                     // power bits sit at 3..2; bits 1..0 ignored
                     power_mode_high_bit <= shift_q[3];
                     power_mode_low_bit  <= shift_q[2];
                     cnt_q               <= 4'h0;
                     sda_oe              <= 1'b1;
                     state_q             <= S_CACK;
                  end
               end
               S_CACK: begin
                  // every further byte is a new command; no count limit
                  if (scl_fall) begin
                     sda_oe  <= 1'b0;
                     state_q <= S_CMD;
                  end
               end
               S_TX: begin
                  if (scl_rise) begin
                     cnt_q <= cnt_inc;
                  end else if (scl_fall) begin
                     if (cnt_q == `ADCSL_BYTE_BITS) begin
                        sda_oe  <= 1'b0;
                        cnt_q   <= 4'h0;
                        state_q <= S_TACK;
                     end else begin
                        tx_q   <= {tx_q[6:0], 1'b0};
                        sda_oe <= ~tx_q[6];
                     end
                  end
               end
               S_TACK: begin
                  if (scl_rise) begin
                     master_ack_q <= ~sda_s;
                  end else if (scl_fall) begin
                     if (master_ack_q) begin
                        tx_q       <= next_byte;
                        sda_oe     <= ~next_byte[7];
                        byte_sel_q <= ~byte_sel_q;
                        if (!byte_sel_q && buf_valid) begin
                           result_q <= buf_data;
                           pop_q    <= 1'b1;
                        end
                        state_q <= S_TX;
                     end else begin
                        sda_oe  <= 1'b0;
                        state_q <= S_IGNORE;
                     end
                  end
               end
               S_IGNORE: begin
                  sda_oe <= 1'b0;
               end
               default: begin
                  sda_oe  <= 1'b0;
                  scl_oe  <= 1'b0;
                  state_q <= S_IDLE;
               end
            endcase
         end
      end
   end
endmodule

// File: tb/adcsl_sva.sv
// assertion checker for the converter two-wire slave port
`timescale 1ns/1ps
module adcsl_sva (
   input wire       clk,
   input wire       rst,
   input wire       scl_in,
   input wire       scl_out,
   input wire       scl_oe,
   input wire       sda_in,
   input wire       sda_out,
   input wire       sda_oe,
   input wire       conv_result_valid,
   input wire       conv_result_ready,
   input wire       conv_start,
   input wire       single_ended_select,
   input wire [2:0] channel_select_bits,
   input wire       power_mode_high_bit,
   input wire       power_mode_low_bit,
   input wire [2:0] pos_input_sel,
   input wire [2:0] neg_input_sel,
   input wire       neg_is_common,
   input wire       high_speed_operation,
   input wire       addressed
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   wire [2:0] c = channel_select_bits;
   // pins are raw here, so the design sees a stop a few cycles later
   sequence s_stop;
      scl_in && $past(scl_in) && $rose(sda_in);
   endsequence
   // decode changes on the same edge as the field; judge it once settled
   sequence s_settled;
      $stable(c) && $stable(single_ended_select);
   endsequence
   a_pins_drive_low: assert property (!scl_out && !sda_out)
      else $error("open drain pin driven high");
   a_data_moves_low: assert property (!$stable(sda_oe) |-> !$past(scl_in))
      else $error("data drive changed while clock high");
   a_ack_needs_match: assert property (sda_oe |-> ##[0:2] addressed)
      else $error("data driven without address match");
   a_start_one_pulse: assert property (conv_start |-> addressed ##1 !conv_start)
      else $error("conversion start not a single addressed pulse");
   a_fields_addressed: assert property (
      !$stable({c, power_mode_high_bit, power_mode_low_bit}) |-> addressed)
      else $error("command fields changed while not addressed");
   a_diff_decode: assert property (s_settled ##0 !single_ended_select |->
      pos_input_sel == {c[1:0], c[2]} && neg_input_sel == {c[1:0], ~c[2]} && !neg_is_common)
      else $error("differential input decode wrong");
   a_se_decode: assert property (s_settled ##0 single_ended_select |->
      pos_input_sel == {c[1:0], c[2]} && neg_is_common)
      else $error("single-ended input decode wrong");
   a_stretch_hs_only: assert property (scl_oe |-> high_speed_operation)
      else $error("clock held low outside high-speed operation");
   a_stretch_release: assert property (
      scl_oe && conv_result_valid && conv_result_ready |-> ##[1:4] !scl_oe)
      else $error("clock not released after result arrived");
   a_stop_ends_hs: assert property (
      s_stop |-> ##[1:6] !high_speed_operation && !addressed)
      else $error("stop did not end transfer and high-speed operation");
endmodule
bind adcsl_slave adcsl_sva u_sva (.clk, .rst, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out,
   .sda_oe, .conv_result_valid, .conv_result_ready, .conv_start, .single_ended_select,
   .channel_select_bits, .power_mode_high_bit, .power_mode_low_bit, .pos_input_sel,
   .neg_input_sel, .neg_is_common, .high_speed_operation, .addressed);

// File: tb/adcsl_master.sv
// two-wire bus master model making every link clock pulse and condition
`timescale 1ns/1ps
module adcsl_master (
   output logic scl_drv,
   output logic sda_drv,
   input  wire  scl_w,
   input  wire  sda_w
);
   // clock stands high between frames, both lines released
   initial begin
      scl_drv = 1'b1;
      sda_drv = 1'b1;
   end
   // odd first delay keeps link edges off the system clock grid
   task automatic start(); // also a repeated start
      #263 sda_drv = 1'b1;
      #250 scl_drv = 1'b1;
      #250 sda_drv = 1'b0;
      #250 scl_drv = 1'b0;
   endtask
   task automatic stop();
      #250 sda_drv = 1'b0;
      #250 scl_drv = 1'b1;
      #250 sda_drv = 1'b1;
      #250;
   endtask
   // low 500 ns, high 300 ns: long low phase gives the slave time to answer
   task automatic bit_x(input logic d, output logic q);
      int n = 0;
      #250 sda_drv = d;
      #250 scl_drv = 1'b1;
      while (scl_w !== 1'b1 && n < 3000) begin // slave may stretch
         #10;
         n++;
      end
      #150 q = sda_w;
      #150 scl_drv = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] d, input logic ack_in,
                       output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--)
         bit_x(d[i], q[i]); // msb first
      bit_x(ack_in, ack);
   endtask
endmodule

// File: tb/tb_adc_two_wire_slave_command_port.sv
// self-checking bench for the converter two-wire slave port
`timescale 1ns/1ps
`include "adcsl_defines.vh"
module tb_adc_two_wire_slave_command_port;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        device_select_high_pin = 1'b0;
   logic        device_select_low_pin = 1'b0;
   logic        conv_result_valid = 1'b0;
   logic [11:0] conv_result = 12'h000;
   wire         scl_out, scl_oe, sda_out, sda_oe, conv_result_ready, conv_start;
   wire         single_ended_select, power_mode_high_bit, power_mode_low_bit;
   wire         neg_is_common, high_speed_operation, addressed, scl_drv, sda_drv;
   wire  [2:0]  channel_select_bits, pos_input_sel, neg_input_sel;
   wire         scl_in = scl_drv & ~scl_oe;
   wire         sda_in = sda_drv & ~sda_oe;
   int          miscompares = 0;
   int          checked = 0;
   int          starts = 0;
   int          cycles = 0;
   logic [6:0]  adr;
   logic [7:0]  q0, q1, cmd;
   logic        a;
   logic [11:0] w [3];
   adcsl_slave dut (.clk, .rst, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe,
      .device_select_high_pin, .device_select_low_pin, .conv_result_valid,
      .conv_result_ready, .conv_result, .conv_start, .single_ended_select,
      .channel_select_bits, .power_mode_high_bit, .power_mode_low_bit, .pos_input_sel,
      .neg_input_sel, .neg_is_common, .high_speed_operation, .addressed);
   adcsl_master m (.scl_drv, .sda_drv, .scl_w(scl_in), .sda_w(sda_in));
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (conv_start === 1'b1)
         starts++;
      if (cycles == 10000) begin
         miscompares++;
         end_sim();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      if (miscompares == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // expected {positive, common flag, negative}; negative unused when single-ended
   function automatic logic [6:0] dec(input logic [3:0] c);
      return c[3] ? {c[1:0], c[2], 4'h8} : {c[1:0], c[2], 1'b0, c[1:0], ~c[2]};
   endfunction
   task automatic push(input logic [11:0] v);
      int n = 0;
      @(posedge clk);
      conv_result_valid <= 1'b1;
      conv_result <= v;
      @(negedge clk);
      while (conv_result_ready !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      if (n >= 200) begin
         miscompares++;
         end_sim();
      end
      @(posedge clk);
      conv_result_valid <= 1'b0;
      conv_result <= ~v;
   endtask
   task automatic wr(input logic [7:0] c);
      int s = starts;
      m.start();
      m.xfer({adr, 1'b0}, 1'b1, q0, a);
      chk(a, 0);
      m.xfer(c, 1'b1, q0, a);
      chk(a, 0);
      chk(starts - s, 1);
      chk({single_ended_select, channel_select_bits, power_mode_high_bit,
           power_mode_low_bit}, c[7:2]);
   endtask
   task automatic rd(input logic [11:0] v, input logic last);
      m.xfer(8'hff, 1'b0, q0, a);
      m.xfer(8'hff, last, q1, a);
      chk({q0, q1}, {4'h0, v});
   endtask
   initial begin
      void'($urandom(10278));
      {device_select_high_pin, device_select_low_pin} <= 2'($urandom);
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (5) @(posedge clk);
      adr = {`ADCSL_TYPE_PREFIX, device_select_high_pin, device_select_low_pin};
      for (int i = 0; i < 16; i++) begin
         cmd = {i[3:0], i[1:0] ^ i[3:2], 2'($urandom)};
         wr(cmd);
         chk({pos_input_sel, neg_is_common, cmd[7] ? 3'h0 : neg_input_sel},
             dec(cmd[7:4]));
      end
      m.stop();
      m.start();
      m.xfer({adr ^ 7'(1 << ($urandom % 7)), 1'b0}, 1'b1, q0, a);
      chk(a, 1);
      m.xfer(8'($urandom), 1'b1, q0, a);
      chk({a, 8'(starts)}, {1'b1, 8'h10});
      m.stop();
      for (int i = 0; i < 2; i++) begin
         w[i] = 12'($urandom);
         push(w[i]);
      end
      repeat (2) @(negedge clk);
      chk(conv_result_ready, 0); // full buffer refuses a third word
      m.start();
      m.xfer({adr, 1'b1}, 1'b1, q0, a);
      chk(a, 0);
      for (int i = 0; i < 3; i++)
         rd(w[i > 1 ? 1 : i], i == 2); // empty buffer repeats the last word
      #400;
      chk(sda_oe, 0);
      m.stop();
      m.start();
      m.xfer({5'h01, 3'($urandom)}, 1'b1, q0, a);
      chk({a, high_speed_operation}, 2'h3);
      wr(8'h8c);
      chk(high_speed_operation, 1);
      w[2] = 12'($urandom);
      fork
         begin
            repeat (120) @(posedge clk);
            push(w[2]);
         end
      join_none
      m.start();
      m.xfer({adr, 1'b1}, 1'b1, q0, a);
      rd(w[2], 1'b1);
      m.stop();
      repeat (8) @(posedge clk);
      chk({high_speed_operation, addressed}, 0);
      end_sim();
   end
endmodule
